// ===== verilog/acc_defines.svh
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// Register byte offsets
`define ACC_OFS_CTRL_ONE   8'h00
`define ACC_OFS_CTRL_TWO   8'h04
`define ACC_OFS_RES_HIGH   8'h08
`define ACC_OFS_RES_LOW    8'h0c
`define ACC_OFS_CMP_HIGH   8'h10
`define ACC_OFS_CMP_LOW    8'h14
`define ACC_OFS_CONFIG     8'h18
`define ACC_OFS_PIN_LOW    8'h1c
`define ACC_OFS_PIN_MID    8'h20
`define ACC_OFS_PIN_UPPER  8'h24

// status_control_one fields
`define ACC_C1_DONE        7
`define ACC_C1_IRQ_EN      6
`define ACC_C1_CONT        5
// status_control_two fields
`define ACC_C2_ACTIVE      7
`define ACC_C2_HW_TRIG     6
`define ACC_C2_CMP_EN      5
`define ACC_C2_CMP_GT      4

// Reset values
`define ACC_RST_CHANNEL    5'h1f
`define ACC_RST_CLKSEL     2'h0
`define ACC_RST_MODE       2'h0
`define ACC_RST_DIV        2'h0

// Field codes
`define ACC_CHAN_OFF       5'h1f
`define ACC_MODE_8BIT      2'h0
`define ACC_MODE_10BIT     2'h2

// Converter clock ticks spent sampling
`define ACC_SAMPLE_TICKS   3'h4

`endif

// ===== verilog/acc_pkg.sv
package acc_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE    = 2'h0,
    ACC_SAMPLE  = 2'h1,
    ACC_CONVERT = 2'h3,
    ACC_DONE    = 2'h2
  } acc_state_type;

  typedef enum logic [1:0] {
    ACC_CLK_BUS   = 2'h0,
    ACC_CLK_HALF  = 2'h1,
    ACC_CLK_ALT   = 2'h2,
    ACC_CLK_ASYNC = 2'h3
  } acc_clksel_type;

  typedef struct packed {
    logic [23:0] hiz;
    logic [23:0] ibuf_dis;
    logic [23:0] pull_dis;
  } acc_pin_ctrl_type;

  typedef struct packed {
    acc_state_type  st;
    logic [4:0]     chan;
    logic           irq_en;
    logic           cont;
    logic           done;
    logic           hwtrig;
    logic           cmp_en;
    logic           cmp_gt;
    logic [1:0]     div;
    logic [1:0]     mode;
    acc_clksel_type clksel;
    logic [1:0]     cvh;
    logic [7:0]     cvl;
    logic [1:0]     res_h;
    logic [7:0]     res_l;
    logic [23:0]    pin_dis;
    logic           lock;
    logic [2:0]     trig_sync;
    logic           half;
    logic           alt_q;
    logic           async_q;
    logic [2:0]     div_cnt;
    logic [2:0]     smp_cnt;
    logic [3:0]     idx;
    logic [10:0]    sar;
    logic [31:0]    prdata;
    logic [23:0]    port_rd;
    logic           irq;
  } acc_regs_type;

endpackage : acc_pkg

// ===== verilog/acc_conv_ctrl.sv
// Functional notes
// - Disabled in reset or channel all ones
// - Idle at lowest power between conversions
// - 10-bit: round 11-bit value, high/low
// - 8-bit: round 9-bit value, low only
// - Set done flag, interrupt when enabled
// - Compare enable checks every result
// - Four clock sources, bus clock after reset
// - Halved bus clock, total division sixteen
// - Async clock runs in wait, stop3
// - Divide source by 1, 2, 4, 8
// - Analog pin forces output high impedance
// - Analog pin disables input, reads zero
// - Analog pin disables pull-up
// - Mid register bit n is channel 8+n
// - Upper register bit n is channel 16+n
// - Hardware select starts on trigger rise
// - Trigger edge during conversion is ignored
// - Continuous: only first trigger edge counts
// - Mode picks width; software or hardware start
// - Mode 00 8-bit, 10 10-bit
// - Clock select code to source mapping
// - Divide codes 00..11 give 1,2,4,8
// - Writing control one with channel starts, unless hardware trigger is selected
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "acc_defines.svh"

module acc_conv_ctrl (
  input  wire logic                      CLK_SYS,
  input  wire logic                      SRST,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [7:0]                PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic                      HW_TRIGGER_INPUT,
  input  wire logic                      ALTERNATE_CLOCK_INPUT,
  input  wire logic                      INTERNAL_ASYNC_CLOCK,
  input  wire logic                      STOP3_MODE,
  input  wire logic                      COMP_IN,
  output logic      [10:0]               DAC_CODE,
  output logic                           SAMPLE_EN,
  output logic                           CONV_POWER,
  output logic                           ASYNC_CLK_EN,
  output logic      [4:0]                CHANNEL_SEL,
  output logic                           CONV_IRQ,
  input  wire logic [23:0]               PORT_PIN_IN,
  output logic      [23:0]               PORT_READ,
  output acc_pkg::acc_pin_ctrl_type      PIN_CTRL
);

  acc_pkg::acc_regs_type r_ff;
  acc_pkg::acc_regs_type nxt_r;

  // Last count of the divider for each ratio code
  function automatic logic [2:0] div_limit(input logic [1:0] code);
    logic [2:0] lim;
    lim = 3'h0;
    unique case (code)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      2'h3: lim = 3'h7;
    endcase
    return lim;
  endfunction : div_limit

  // Drop the extra bit with round-half-up, saturating at full scale
  function automatic logic [9:0] round_res(input logic [10:0] sar, input logic ten);
    logic [10:0] sum;
    sum = 11'h000;
    if (ten) begin
      sum = {1'b0, sar[10:1]} + {10'h000, sar[0]};
      return sum[10] ? 10'h3ff : sum[9:0];
    end
    sum = {3'h0, sar[10:3]} + {10'h000, sar[2]};
    return sum[8] ? 10'h0ff : {2'h0, sum[7:0]};
  endfunction : round_res

  function automatic logic [31:0] read_mux(input acc_pkg::acc_regs_type s, input logic [7:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (addr)
      `ACC_OFS_CTRL_ONE:  d = {24'h0, s.done, s.irq_en, s.cont, s.chan};
      `ACC_OFS_CTRL_TWO:  d = {24'h0, s.st != acc_pkg::ACC_IDLE, s.hwtrig, s.cmp_en, s.cmp_gt, 4'h0};
      `ACC_OFS_RES_HIGH:  d = {30'h0, s.res_h};
      `ACC_OFS_RES_LOW:   d = {24'h0, s.res_l};
      `ACC_OFS_CMP_HIGH:  d = {30'h0, s.cvh};
      `ACC_OFS_CMP_LOW:   d = {24'h0, s.cvl};
      `ACC_OFS_CONFIG:    d = {25'h0, s.div, 1'b0, s.mode, s.clksel};
      `ACC_OFS_PIN_LOW:   d = {24'h0, s.pin_dis[7:0]};
      `ACC_OFS_PIN_MID:   d = {24'h0, s.pin_dis[15:8]};
      `ACC_OFS_PIN_UPPER: d = {24'h0, s.pin_dis[23:16]};
      default:            d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  function automatic logic mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= `ACC_OFS_PIN_UPPER);
  endfunction : mapped

  always_comb begin
    logic        wr;
    logic        rd;
    logic        src_tick;
    logic        tick;
    logic        start;
    logic        abort;
    logic        trig_edge;
    logic        ten;
    logic [9:0]  res;
    logic [9:0]  cv;
    logic        cmp_ok;
    logic        blocked;
    wr        = 1'b0;
    rd        = 1'b0;
    src_tick  = 1'b0;
    tick      = 1'b0;
    start     = 1'b0;
    abort     = 1'b0;
    trig_edge = 1'b0;
    ten       = 1'b0;
    res       = 10'h000;
    cv        = 10'h000;
    cmp_ok    = 1'b0;
    blocked   = 1'b0;
    nxt_r     = r_ff;

    wr = PSEL && PENABLE && PWRITE;
    rd = PSEL && PENABLE && !PWRITE;
    ten = (r_ff.mode == `ACC_MODE_10BIT);

    // Second stage feeds the edge detector; first stage only feeds the second
    nxt_r.trig_sync = {r_ff.trig_sync[1:0], HW_TRIGGER_INPUT};
    trig_edge = r_ff.trig_sync[1] && !r_ff.trig_sync[2];

    nxt_r.half    = !r_ff.half;
    nxt_r.alt_q   = ALTERNATE_CLOCK_INPUT;
    nxt_r.async_q = INTERNAL_ASYNC_CLOCK;
    unique case (r_ff.clksel)
      acc_pkg::ACC_CLK_BUS:   src_tick = 1'b1;
      acc_pkg::ACC_CLK_HALF:  src_tick = r_ff.half;
      acc_pkg::ACC_CLK_ALT:   src_tick = ALTERNATE_CLOCK_INPUT && !r_ff.alt_q;
      acc_pkg::ACC_CLK_ASYNC: src_tick = INTERNAL_ASYNC_CLOCK && !r_ff.async_q;
    endcase

    // Converter clock only runs while a conversion is active
    if (r_ff.st == acc_pkg::ACC_IDLE) begin
      nxt_r.div_cnt = 3'h0;
    end else if (src_tick) begin
      if (r_ff.div_cnt >= div_limit(r_ff.div)) begin
        nxt_r.div_cnt = 3'h0;
        tick = 1'b1;
      end else begin
        nxt_r.div_cnt = r_ff.div_cnt + 3'h1;
      end
    end

    // Register writes; any control, compare or configuration write invalidates a running conversion
    nxt_r.prdata = (PSEL && !PENABLE) ? read_mux(r_ff, PADDR) : r_ff.prdata;
    if (wr && mapped(PADDR)) begin
      unique case (PADDR)
        `ACC_OFS_CTRL_ONE: begin
          nxt_r.chan   = PWDATA[4:0];
          nxt_r.cont   = PWDATA[`ACC_C1_CONT];
          nxt_r.irq_en = PWDATA[`ACC_C1_IRQ_EN];
          nxt_r.done   = 1'b0;
          abort = 1'b1;
          start = (PWDATA[4:0] != `ACC_CHAN_OFF) && !r_ff.hwtrig;
        end
        `ACC_OFS_CTRL_TWO: begin
          nxt_r.hwtrig = PWDATA[`ACC_C2_HW_TRIG];
          nxt_r.cmp_en = PWDATA[`ACC_C2_CMP_EN];
          nxt_r.cmp_gt = PWDATA[`ACC_C2_CMP_GT];
          abort = 1'b1;
        end
        `ACC_OFS_CMP_HIGH: begin
          nxt_r.cvh = PWDATA[1:0];
          abort = 1'b1;
        end
        `ACC_OFS_CMP_LOW: begin
          nxt_r.cvl = PWDATA[7:0];
          abort = 1'b1;
        end
        `ACC_OFS_CONFIG: begin
          nxt_r.div    = PWDATA[6:5];
          nxt_r.mode   = PWDATA[3:2];
          nxt_r.clksel = acc_pkg::acc_clksel_type'(PWDATA[1:0]);
          abort = 1'b1;
        end
        `ACC_OFS_PIN_LOW:   nxt_r.pin_dis[7:0]   = PWDATA[7:0];
        `ACC_OFS_PIN_MID:   nxt_r.pin_dis[15:8]  = PWDATA[7:0];
        `ACC_OFS_PIN_UPPER: nxt_r.pin_dis[23:16] = PWDATA[7:0];
        default: ;
      endcase
    end

    // Reading the high half in 10-bit mode holds back new results until the low half is read
    if (rd && PADDR == `ACC_OFS_RES_HIGH && ten) begin
      nxt_r.lock = 1'b1;
    end
    if (rd && PADDR == `ACC_OFS_RES_LOW) begin
      nxt_r.lock = 1'b0;
    end

    // Edges outside idle fall through, so continuous runs see only the first
    if (r_ff.hwtrig && trig_edge && r_ff.st == acc_pkg::ACC_IDLE && !abort) begin
      start = 1'b1;
    end

    unique case (r_ff.st)
      acc_pkg::ACC_IDLE: begin
        if (start) begin
          nxt_r.st      = acc_pkg::ACC_SAMPLE;
          nxt_r.smp_cnt = 3'h0;
        end
      end
      acc_pkg::ACC_SAMPLE: begin
        if (tick) begin
          if (r_ff.smp_cnt == `ACC_SAMPLE_TICKS - 3'h1) begin
            nxt_r.st  = acc_pkg::ACC_CONVERT;
            nxt_r.sar = 11'h400;
            nxt_r.idx = 4'ha;
          end else begin
            nxt_r.smp_cnt = r_ff.smp_cnt + 3'h1;
          end
        end
      end
      acc_pkg::ACC_CONVERT: begin
        if (tick) begin
          nxt_r.sar[r_ff.idx] = COMP_IN;
          if (r_ff.idx == (ten ? 4'h0 : 4'h2)) begin
            nxt_r.st = acc_pkg::ACC_DONE;
          end else begin
            nxt_r.idx = r_ff.idx - 4'h1;
            nxt_r.sar[r_ff.idx - 4'h1] = 1'b1;
          end
        end
      end
      acc_pkg::ACC_DONE: begin
        res = round_res(r_ff.sar, ten);
        cv  = ten ? {r_ff.cvh, r_ff.cvl} : {2'h0, r_ff.cvl};
        cmp_ok = !r_ff.cmp_en || (r_ff.cmp_gt ? (res >= cv) : (res < cv));
        blocked = r_ff.lock && ten;
        if (cmp_ok && !blocked) begin
          nxt_r.res_l = res[7:0];
          nxt_r.res_h = ten ? res[9:8] : 2'h0;
          nxt_r.done  = 1'b1;
        end
        if ((r_ff.cont || blocked) && !(!r_ff.cont && !cmp_ok)) begin
          nxt_r.st      = acc_pkg::ACC_SAMPLE;
          nxt_r.smp_cnt = 3'h0;
        end else begin
          nxt_r.st = acc_pkg::ACC_IDLE;
        end
      end
    endcase

    // Abort wins over the state machine but never over a flag being set
    if (abort) begin
      nxt_r.st = start ? acc_pkg::ACC_SAMPLE : acc_pkg::ACC_IDLE;
      nxt_r.smp_cnt = 3'h0;
    end
    if (nxt_r.chan == `ACC_CHAN_OFF || (STOP3_MODE && r_ff.clksel != acc_pkg::ACC_CLK_ASYNC)) begin
      nxt_r.st = acc_pkg::ACC_IDLE;
    end

    nxt_r.irq = nxt_r.done && nxt_r.irq_en;
    nxt_r.port_rd = PORT_PIN_IN & ~r_ff.pin_dis;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      r_ff         <= '0;
      r_ff.st      <= acc_pkg::ACC_IDLE;
      r_ff.chan    <= `ACC_RST_CHANNEL;
      r_ff.clksel  <= acc_pkg::acc_clksel_type'(`ACC_RST_CLKSEL);
      r_ff.mode    <= `ACC_RST_MODE;
      r_ff.div     <= `ACC_RST_DIV;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Zero-wait slave: read data was captured during the setup cycle
  assign PRDATA       = r_ff.prdata;
  assign PREADY       = 1'b1;
  assign PSLVERR      = PSEL && PENABLE && !mapped(PADDR);

  assign DAC_CODE     = r_ff.sar;
  assign SAMPLE_EN    = r_ff.st == acc_pkg::ACC_SAMPLE;
  assign CONV_POWER   = r_ff.st != acc_pkg::ACC_IDLE;
  assign ASYNC_CLK_EN = CONV_POWER && r_ff.clksel == acc_pkg::ACC_CLK_ASYNC;
  assign CHANNEL_SEL  = r_ff.chan;
  assign CONV_IRQ     = r_ff.irq;
  assign PORT_READ    = r_ff.port_rd;

  assign PIN_CTRL.hiz      = r_ff.pin_dis;
  assign PIN_CTRL.ibuf_dis = r_ff.pin_dis;
  assign PIN_CTRL.pull_dis = r_ff.pin_dis;

endmodule : acc_conv_ctrl

// ===== sim/acc_conv_ctrl_assertions.sv
`timescale 1ns/1ns
module acc_conv_ctrl_assertions (
  input wire logic                CLK_SYS,
  input wire logic                SRST,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  input wire logic [10:0]         DAC_CODE,
  input wire logic                SAMPLE_EN,
  input wire logic                CONV_POWER,
  input wire logic                ASYNC_CLK_EN,
  input wire logic [4:0]          CHANNEL_SEL,
  input wire logic [23:0]         PORT_READ,
  input acc_pkg::acc_pin_ctrl_type PIN_CTRL
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  a_reset_clears: assert property ($fell(SRST) |-> !CONV_POWER && CHANNEL_SEL == 5'h1f && PIN_CTRL == '0)
    else $error("state not cleared by reset");
  a_chan_off: assert property (CHANNEL_SEL == 5'h1f ##1 CHANNEL_SEL == 5'h1f |-> !CONV_POWER)
    else $error("converter active with channel off");
  a_start_sample: assert property ($rose(CONV_POWER) |-> SAMPLE_EN)
    else $error("conversion did not begin by sampling");
  a_sample_power: assert property (SAMPLE_EN |-> CONV_POWER)
    else $error("sampling while powered down");
  a_first_trial: assert property ($fell(SAMPLE_EN) && CONV_POWER |-> DAC_CODE == 11'h400)
    else $error("first trial code wrong");
  a_async_power: assert property (ASYNC_CLK_EN |-> CONV_POWER)
    else $error("async clock enabled while idle");
  a_pin_alike: assert property (PIN_CTRL.hiz == PIN_CTRL.pull_dis && PIN_CTRL.hiz == PIN_CTRL.ibuf_dis)
    else $error("pin controls disagree");
  a_port_zero: assert property ((PORT_READ & PIN_CTRL.ibuf_dis & $past(PIN_CTRL.ibuf_dis)) == 24'h0)
    else $error("analog pin reads nonzero");
  a_err_access: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error outside access phase");
  a_ready_access: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access phase not ready");
endmodule : acc_conv_ctrl_assertions

bind acc_conv_ctrl acc_conv_ctrl_assertions u_acc_conv_ctrl_assertions (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DAC_CODE(DAC_CODE), .SAMPLE_EN(SAMPLE_EN), .CONV_POWER(CONV_POWER), .ASYNC_CLK_EN(ASYNC_CLK_EN),
  .CHANNEL_SEL(CHANNEL_SEL), .PORT_READ(PORT_READ), .PIN_CTRL(PIN_CTRL)
);

// ===== sim/acc_analog_model.sv
`timescale 1ns/1ns
module acc_analog_model (
  input  wire logic        clk,
  input  wire logic [10:0] dac_code,
  input  wire logic [10:0] level,
  input  wire logic        fire,
  output logic             comp_in,
  output logic             trig
);
  logic [2:0] hold_ff = 3'h0;
  // Comparator settles well within one tick
  assign comp_in = level >= dac_code;
  // Pulse held long enough for a two-flop synchroniser
  always_ff @(posedge clk) begin
    hold_ff <= fire ? 3'h4 : (hold_ff != 3'h0 ? hold_ff - 3'h1 : 3'h0);
  end
  assign trig = hold_ff != 3'h0;
endmodule : acc_analog_model

// ===== sim/acc_conv_ctrl_tb_top.sv
`timescale 1ns/1ns
module acc_conv_ctrl_tb_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig;
  logic        fire = 1'b0;
  logic        stop3 = 1'b0;
  logic [2:0]  slow = 3'h0;
  logic        comp;
  logic [10:0] dac;
  logic [10:0] level = 11'h0;
  logic        sample_en;
  logic        conv_power;
  logic        async_en;
  logic [4:0]  chan;
  logic        irq;
  logic [23:0] pin_in = 24'h0;
  logic [23:0] port_rd;
  logic [31:0] rdat;
  logic        rerr;
  int          fails = 0;
  int          comparisons = 0;
  int          cyc;
  acc_pkg::acc_pin_ctrl_type pin_ctrl;

  always #50 clk = ~clk;
  // Alternate clock ticks every 4 cycles, async every 8
  always @(posedge clk) slow <= slow + 3'h1;

  acc_conv_ctrl u_acc_conv_ctrl (
    .CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HW_TRIGGER_INPUT(trig), .ALTERNATE_CLOCK_INPUT(slow[1]), .INTERNAL_ASYNC_CLOCK(slow[2]),
    .STOP3_MODE(stop3), .COMP_IN(comp), .DAC_CODE(dac), .SAMPLE_EN(sample_en),
    .CONV_POWER(conv_power), .ASYNC_CLK_EN(async_en), .CHANNEL_SEL(chan), .CONV_IRQ(irq),
    .PORT_PIN_IN(pin_in), .PORT_READ(port_rd), .PIN_CTRL(pin_ctrl)
  );
  acc_analog_model u_acc_analog_model (
    .clk(clk), .dac_code(dac), .level(level), .fire(fire), .comp_in(comp), .trig(trig)
  );

  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a slave that never answers
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wait_pwr(input logic v);
    cyc = 0;
    while (conv_power !== v && cyc < 3000) begin
      @(posedge clk);
      cyc++;
    end
    if (cyc == 3000)
      fails++;
  endtask : wait_pwr

  task automatic pulse;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask : pulse

  task automatic t_reset;
    xfer(1'b0, 8'h18, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h1f);
    chk(conv_power, 1'b0);
    chk(chan, 32'h1f);
    $display("test reset finished");
  endtask : t_reset

  task automatic t_conv;
    logic [27:0] tbl [5] = '{28'h22a5153, 28'h27ff3ff, 28'h02a5055, 28'h07ff0ff, 28'h32a5055};
    logic [27:0] e;
    for (int i = 0; i < 5; i++) begin
      e = tbl[i];
      level <= e[22:12];
      xfer(1'b1, 8'h18, {28'h0, e[25:24], 2'h0});
      xfer(1'b1, 8'h00, 32'h40);
      wait_pwr(1'b1);
      wait_pwr(1'b0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      xfer(1'b0, 8'h00, 32'h0);
      chk(rdat[7], 1'b1);
      xfer(1'b0, 8'h08, 32'h0);
      chk(rdat, e[11:8]);
      xfer(1'b0, 8'h0c, 32'h0);
      chk(rdat, e[7:0]);
      chk(conv_power, 1'b0);
    end
    // High half read in 10-bit mode blocks results until the low half is read
    xfer(1'b1, 8'h18, 32'h08);
    xfer(1'b0, 8'h08, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    wait_pwr(1'b1);
    repeat (40) @(posedge clk);
    chk(conv_power, 1'b1);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat[7], 1'b0);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h55);
    wait_pwr(1'b0);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat[7], 1'b1);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h53);
    $display("test conversion finished");
  endtask : t_conv

  task automatic t_clk;
    logic [15:0] tbl [7] = '{16'h0001, 16'h0102, 16'h0204, 16'h0308, 16'h1310, 16'h2004, 16'h3008};
    logic [15:0] e;
    int r;
    for (int i = 0; i < 7; i++) begin
      e = tbl[i];
      r = e[7:0];
      // Async source must keep converting with stop3 active
      stop3 <= (i == 6);
      xfer(1'b1, 8'h18, {25'h0, e[9:8], 3'h0, e[13:12]});
      xfer(1'b1, 8'h00, 32'h0);
      wait_pwr(1'b1);
      chk(async_en, e[13:12] == 2'h3);
      wait_pwr(1'b0);
      // Free-running source: first tick lands anywhere within one ratio
      chk(32'(cyc >= 12 * r + 2 && cyc <= 13 * r + 1), 1);
    end
    xfer(1'b1, 8'h18, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge clk);
    chk(conv_power, 1'b0);
    stop3 <= 1'b0;
    $display("test clock finished");
  endtask : t_clk

  task automatic t_hw;
    xfer(1'b1, 8'h18, 32'h60);
    xfer(1'b1, 8'h04, 32'h40);
    xfer(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk);
    chk(conv_power, 1'b0);
    pulse;
    wait_pwr(1'b1);
    chk(32'(cyc >= 2 && cyc <= 7), 1);
    repeat (20) @(posedge clk);
    pulse;
    wait_pwr(1'b0);
    repeat (20) @(posedge clk);
    chk(conv_power, 1'b0);
    xfer(1'b1, 8'h00, 32'h20);
    pulse;
    wait_pwr(1'b1);
    repeat (60) @(posedge clk);
    pulse;
    repeat (300) @(posedge clk);
    chk(conv_power, 1'b1);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat[7], 1'b1);
    xfer(1'b1, 8'h00, 32'h1f);
    repeat (2) @(posedge clk);
    chk(conv_power, 1'b0);
    $display("test trigger finished");
  endtask : t_hw

  task automatic t_cmp;
    level <= 11'h2a5;
    xfer(1'b1, 8'h18, 32'h08);
    xfer(1'b1, 8'h10, 32'h3);
    xfer(1'b1, 8'h14, 32'hff);
    xfer(1'b1, 8'h04, 32'h30);
    xfer(1'b1, 8'h00, 32'h0);
    wait_pwr(1'b1);
    wait_pwr(1'b0);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat[7], 1'b0);
    xfer(1'b1, 8'h04, 32'h20);
    xfer(1'b1, 8'h00, 32'h0);
    wait_pwr(1'b1);
    wait_pwr(1'b0);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdat[7], 1'b1);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h53);
    $display("test compare finished");
  endtask : t_cmp

  task automatic t_pins;
    pin_in <= 24'hffffff;
    xfer(1'b1, 8'h1c, 32'ha5);
    xfer(1'b1, 8'h20, 32'h3c);
    xfer(1'b1, 8'h24, 32'h81);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h3c);
    xfer(1'b0, 8'h24, 32'h0);
    chk(rdat, 32'h81);
    chk(pin_ctrl.hiz, 24'h813ca5);
    chk(pin_ctrl.pull_dis, 24'h813ca5);
    chk(pin_ctrl.ibuf_dis, 24'h813ca5);
    chk(port_rd, 24'h7ec35a);
    xfer(1'b0, 8'h28, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    $display("test pins finished");
  endtask : t_pins

  initial begin
    #2000000;
    fails++;
    test_done;
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_conv;
    t_clk;
    t_hw;
    t_cmp;
    t_pins;
    test_done;
  end
endmodule : acc_conv_ctrl_tb_top
